// *** core/pea_pkg.sv ***
package pea_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] PEA_ADDR_WAKE_ERR = 8'h0e2;
  localparam logic [7:0] PEA_ADDR_STATUS   = 8'h0e4;
  localparam logic [7:0] PEA_ADDR_IRQ_STAT = 8'h0f8;
  localparam logic [7:0] PEA_ADDR_IRQ_MASK = 8'h0fa;
  // Status word field positions
  localparam int PEA_BIT_RSVD15   = 15;
  localparam int PEA_BIT_HWEEE    = 14;
  localparam int PEA_BIT_TXLPILAT = 13;
  localparam int PEA_BIT_TXLPI    = 12;
  localparam int PEA_BIT_RXLPILAT = 11;
  localparam int PEA_BIT_RXLPI    = 10;
  localparam int PEA_BIT_NPLOCABL = 6;
  localparam int PEA_BIT_NPLOC    = 5;
  localparam int PEA_BIT_PDFAULT  = 4;
  localparam int PEA_BIT_LPNPABL  = 3;
  localparam int PEA_BIT_NPABL    = 2;
  localparam int PEA_BIT_PAGERX   = 1;
  localparam int PEA_BIT_LPANABL  = 0;
  // Reset values
  localparam logic [15:0] PEA_RST_WAKE_ERR = 16'h0000;
  localparam logic [15:0] PEA_RST_IRQ_MASK = 16'h0000;
  localparam logic [15:0] PEA_WAKE_ERR_MAX = 16'hffff;
  // Wake time that defines a wake error, in ns, and in clock cycles at 100 MHz
  localparam int PEA_WAKE_TIME_NS  = 20500;
  localparam int PEA_CLK_PERIOD_NS = 10;
  localparam int PEA_WAKE_CYCLES   = PEA_WAKE_TIME_NS / PEA_CLK_PERIOD_NS;
  // Interrupt event bits
  localparam int PEA_IRQ_WAKEERR = 0;
  localparam int PEA_IRQ_TXLPI   = 1;
  localparam int PEA_IRQ_RXLPI   = 2;
  localparam int PEA_IRQ_PDFAULT = 3;
  localparam int PEA_IRQ_PAGERX  = 4;

  // Live inputs from the port's PHY and auto-negotiation logic
  typedef struct packed {
    logic wakeTimerDone;
    logic txLpiActive;
    logic rxLpiActive;
    logic hwEeeEnabled;
    logic partnerNextPageAble;
    logic partnerAutonegAble;
    logic parallelDetectFault;
    logic pageReceived;
  } pea_phy_t;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pea_bus_t;
endpackage

// *** core/pea_status_regs.sv ***
`timescale 1ns/1ns
// Operation
// - Each false-to-true change of the wake timer expiry adds one to the wake error counter.
// - The wake error counter saturates at all ones, resets to zero and clears after a read.
// - Status bit 14 shows whether hardware EEE was enabled by the next-page exchange.
// - Status bit 13 latches high when the transmit PCS has seen LPI.
// - Bits 13 and 11 hold high until software writes a one to them, which clears them.
// - Status bit 12 follows the live transmit PCS LPI state.
// - Status bit 11 latches high when the receive PCS has seen LPI.
// - Status bit 10 follows the live receive PCS LPI state.
// - Status bit 6 reads one, meaning bit 5 gives the next-page store location.
// - Status bit 5 selects the next-page store: one for the dedicated pair, zero for base pair.
// - Status bit 4 latches a parallel detection fault and clears on a read of the word.
// - Status bit 3 shows partner next-page capability.
// - Status bit 2 reads one since the local port supports next-page exchange.
// - Status bit 1 latches high when a new page is received.
// - Status bit 0 shows partner auto-negotiation capability.
module pea_status_regs
  import pea_pkg::*;
#(
  parameter logic NP_STORE_DEDICATED = 1'b1
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire pea_bus_t    bus,
  output logic      [15:0] rdData,
  input  wire pea_phy_t    phyIn,
  output logic             irq
);

  // Two-stage synchronisers for the PHY-side levels
  // The PHY levels come from another clock, so nothing but the second stage reads
  // phyMeta_q; live status bits lag their pins by two cycles, latched bits by three.
  pea_phy_t phyMeta_q;
  pea_phy_t phySync_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      phyMeta_q <= '0;
      phySync_q <= '0;
    end else begin
      phyMeta_q <= phyIn;
      phySync_q <= phyMeta_q;
    end
  end

  // Previous wake-timer level for edge detection
  // Reset low matches the idle level of the expiry pin, so no false edge follows reset.
  logic wakePrev_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      wakePrev_q <= 1'b0;
    end else begin
      wakePrev_q <= phySync_q.wakeTimerDone;
    end
  end

  logic wakeRise;
  assign wakeRise = phySync_q.wakeTimerDone && !wakePrev_q;

  // Access decodes
  logic rdWake, rdStat, wrStat, rdIrqS, wrMask;
  assign rdWake = bus.rd && (bus.addr == PEA_ADDR_WAKE_ERR);
  assign rdStat = bus.rd && (bus.addr == PEA_ADDR_STATUS);
  assign wrStat = bus.wr && (bus.addr == PEA_ADDR_STATUS);
  assign rdIrqS = bus.rd && (bus.addr == PEA_ADDR_IRQ_STAT);
  assign wrMask = bus.wr && (bus.addr == PEA_ADDR_IRQ_MASK);

  // Wake error counter: saturating, clear on read, event wins over clear
  // A read in the cycle of a wake edge returns the old count and leaves one,
  // so no error is lost between the read and the clear.
  logic [15:0] wakeCnt_q;
  logic [15:0] wakeCnt_d;
  always_comb begin
    wakeCnt_d = wakeCnt_q;
    if (rdWake) begin
      wakeCnt_d = 16'h0000;
    end
    if (wakeRise) begin
      if (rdWake) begin
        wakeCnt_d = 16'h0001;
      end else if (wakeCnt_q != PEA_WAKE_ERR_MAX) begin
        wakeCnt_d = wakeCnt_q + 16'h0001;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      wakeCnt_q <= PEA_RST_WAKE_ERR;
    end else begin
      wakeCnt_q <= wakeCnt_d;
    end
  end

  // Latched status bits; a set in the clearing cycle wins
  // The LPI latches are set while their input is high, so a clear written while
  // LPI is still present leaves the bit set and software must clear it again.
  logic txLat_q, rxLat_q, pdf_q, pageRx_q;
  logic clrTx, clrRx;
  assign clrTx = wrStat && bus.wdata[PEA_BIT_TXLPILAT];
  assign clrRx = wrStat && bus.wdata[PEA_BIT_RXLPILAT];

  // Transmit LPI seen, cleared by writing a one
  always_ff @(posedge mclk) begin
    if (srst) begin
      txLat_q <= 1'b0;
    end else begin
      txLat_q <= phySync_q.txLpiActive || (txLat_q && !clrTx);
    end
  end

  // Receive LPI seen, cleared by writing a one
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxLat_q <= 1'b0;
    end else begin
      rxLat_q <= phySync_q.rxLpiActive || (rxLat_q && !clrRx);
    end
  end

  // Parallel detection fault, cleared by a read of the status word
  always_ff @(posedge mclk) begin
    if (srst) begin
      pdf_q <= 1'b0;
    end else begin
      pdf_q <= phySync_q.parallelDetectFault || (pdf_q && !rdStat);
    end
  end

  // Page received, cleared by a read of the status word
  always_ff @(posedge mclk) begin
    if (srst) begin
      pageRx_q <= 1'b0;
    end else begin
      pageRx_q <= phySync_q.pageReceived || (pageRx_q && !rdStat);
    end
  end

  // Assembled status word
  // Bits 9 to 7 stay zero and bit 15 one, whatever software writes there.
  logic [15:0] statWord;
  always_comb begin
    statWord = 16'h0000;
    statWord[PEA_BIT_RSVD15]   = 1'b1;
    statWord[PEA_BIT_HWEEE]    = phySync_q.hwEeeEnabled;
    statWord[PEA_BIT_TXLPILAT] = txLat_q;
    statWord[PEA_BIT_TXLPI]    = phySync_q.txLpiActive;
    statWord[PEA_BIT_RXLPILAT] = rxLat_q;
    statWord[PEA_BIT_RXLPI]    = phySync_q.rxLpiActive;
    statWord[PEA_BIT_NPLOCABL] = 1'b1;
    statWord[PEA_BIT_NPLOC]    = NP_STORE_DEDICATED;
    statWord[PEA_BIT_PDFAULT]  = pdf_q;
    statWord[PEA_BIT_LPNPABL]  = phySync_q.partnerNextPageAble;
    statWord[PEA_BIT_NPABL]    = 1'b1;
    statWord[PEA_BIT_PAGERX]   = pageRx_q;
    statWord[PEA_BIT_LPANABL]  = phySync_q.partnerAutonegAble;
  end

  // Interrupt events, sticky status cleared by read, and mask
  // An event fires in the cycle its latch goes from low to high, so a level that
  // stays high raises its sticky bit only once, as the latch cannot clear while it lasts.
  logic [4:0] irqEv;
  logic [4:0] irqStat_q;
  logic [4:0] irqMask_q;
  assign irqEv[PEA_IRQ_WAKEERR] = wakeRise;
  assign irqEv[PEA_IRQ_TXLPI]   = phySync_q.txLpiActive && !txLat_q;
  assign irqEv[PEA_IRQ_RXLPI]   = phySync_q.rxLpiActive && !rxLat_q;
  assign irqEv[PEA_IRQ_PDFAULT] = phySync_q.parallelDetectFault && !pdf_q;
  assign irqEv[PEA_IRQ_PAGERX]  = phySync_q.pageReceived && !pageRx_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      irqStat_q <= 5'h00;
    end else begin
      irqStat_q <= irqEv | (rdIrqS ? 5'h00 : irqStat_q);
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      irqMask_q <= PEA_RST_IRQ_MASK[4:0];
    end else if (wrMask) begin
      irqMask_q <= bus.wdata[4:0];
    end
  end
  assign irq = |(irqStat_q & irqMask_q);

  // Read data, one cycle after the strobe; zero when idle or unmapped
  // Driving zero outside the answer cycle keeps stale values off the bus.
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdData <= 16'h0000;
    end else if (bus.rd) begin
      case (bus.addr)
        PEA_ADDR_WAKE_ERR: rdData <= wakeCnt_q;
        PEA_ADDR_STATUS:   rdData <= statWord;
        PEA_ADDR_IRQ_STAT: rdData <= {11'h000, irqStat_q};
        PEA_ADDR_IRQ_MASK: rdData <= {11'h000, irqMask_q};
        default:           rdData <= 16'h0000;
      endcase
    end else begin
      rdData <= 16'h0000;
    end
  end

  // Synchroniser stages
  AST_SYNC_META: assert property (@(posedge mclk) disable iff (srst)
    1'b1 |=> (phyMeta_q == $past(phyIn)))
    else $error("first sync stage missed its input");
  AST_SYNC_SECOND: assert property (@(posedge mclk) disable iff (srst)
    1'b1 |=> (phySync_q == $past(phyMeta_q)))
    else $error("second sync stage missed its input");

  // Wake error counter
  AST_WAKE_HOLD: assert property (@(posedge mclk) disable iff (srst)
    (!wakeRise && !rdWake) |=> (wakeCnt_q == $past(wakeCnt_q)))
    else $error("wake counter changed without cause");
  AST_WAKE_RDSET: assert property (@(posedge mclk) disable iff (srst)
    (rdWake && wakeRise) |=> (wakeCnt_q == 16'h0001))
    else $error("wake edge lost during read");
  AST_WAKE_EDGE: assert property (@(posedge mclk) disable iff (srst)
    wakeRise |=> !wakeRise)
    else $error("wake edge longer than one cycle");
  AST_WAKE_RDDATA: assert property (@(posedge mclk) disable iff (srst)
    rdWake |=> (rdData == $past(wakeCnt_q)))
    else $error("wake counter read data wrong");
  AST_WAKE_RST: assert property (@(posedge mclk)
    srst |=> (wakeCnt_q == PEA_RST_WAKE_ERR))
    else $error("wake counter not reset");
  AST_WAKE_INC: assert property (@(posedge mclk) disable iff (srst)
    (wakeRise && !rdWake && wakeCnt_q != 16'hffff) |=> (wakeCnt_q == $past(wakeCnt_q) + 16'h0001))
    else $error("wake counter did not increment");
  AST_WAKE_SAT: assert property (@(posedge mclk) disable iff (srst)
    (wakeCnt_q == 16'hffff && !rdWake) |=> (wakeCnt_q == 16'hffff))
    else $error("wake counter left saturation");
  AST_WAKE_CLR: assert property (@(posedge mclk) disable iff (srst)
    (rdWake && !wakeRise) |=> (wakeCnt_q == 16'h0000) && (rdData == $past(wakeCnt_q)))
    else $error("wake counter read did not clear");

  // LPI latches, set by the live level and cleared by writing a one
  AST_TX_LATCH: assert property (@(posedge mclk) disable iff (srst)
    phySync_q.txLpiActive |=> txLat_q)
    else $error("tx lpi latch missed");
  AST_RX_LATCH: assert property (@(posedge mclk) disable iff (srst)
    phySync_q.rxLpiActive |=> rxLat_q)
    else $error("rx lpi latch missed");
  AST_TX_HOLD: assert property (@(posedge mclk) disable iff (srst)
    (txLat_q && !clrTx) |=> txLat_q)
    else $error("tx lpi latch dropped");
  AST_RX_CLR: assert property (@(posedge mclk) disable iff (srst)
    (clrRx && !phySync_q.rxLpiActive) |=> !rxLat_q)
    else $error("rx lpi latch not cleared");
  AST_TX_NOSET: assert property (@(posedge mclk) disable iff (srst)
    (!txLat_q && !phySync_q.txLpiActive) |=> !txLat_q)
    else $error("tx lpi latch set without lpi");
  AST_RX_NOSET: assert property (@(posedge mclk) disable iff (srst)
    (!rxLat_q && !phySync_q.rxLpiActive) |=> !rxLat_q)
    else $error("rx lpi latch set without lpi");
  AST_LAT_HOLD: assert property (@(posedge mclk) disable iff (srst)
    (rxLat_q && !clrRx) |=> rxLat_q)
    else $error("rx lpi latch dropped");
  AST_LAT_CLR: assert property (@(posedge mclk) disable iff (srst)
    (clrTx && !phySync_q.txLpiActive) |=> !txLat_q)
    else $error("tx lpi latch not cleared");

  // Latches cleared by a read of the status word; writes leave them alone
  AST_PAGE_CLR: assert property (@(posedge mclk) disable iff (srst)
    (rdStat && !phySync_q.pageReceived) |=> !pageRx_q)
    else $error("page received not cleared on read");
  AST_PDF_LATCH: assert property (@(posedge mclk) disable iff (srst)
    phySync_q.parallelDetectFault |=> pdf_q)
    else $error("parallel fault not latched");
  AST_PDF_HOLD: assert property (@(posedge mclk) disable iff (srst)
    (pdf_q && !rdStat) |=> pdf_q)
    else $error("parallel fault dropped");
  AST_PDF_CLR: assert property (@(posedge mclk) disable iff (srst)
    (rdStat && !phySync_q.parallelDetectFault) |=> !pdf_q)
    else $error("parallel fault not cleared on read");
  AST_PAGE_LATCH: assert property (@(posedge mclk) disable iff (srst)
    phySync_q.pageReceived |=> pageRx_q)
    else $error("page received not latched");
  AST_PAGE_HOLD: assert property (@(posedge mclk) disable iff (srst)
    (pageRx_q && !rdStat) |=> pageRx_q)
    else $error("page received dropped");
  AST_WR_PAGE: assert property (@(posedge mclk) disable iff (srst)
    (wrStat && !phySync_q.pageReceived) |=> (pageRx_q == $past(pageRx_q)))
    else $error("write changed page received");
  AST_WR_PDF: assert property (@(posedge mclk) disable iff (srst)
    (wrStat && !phySync_q.parallelDetectFault) |=> (pdf_q == $past(pdf_q)))
    else $error("write changed parallel fault");

  // Status word read path
  // Each field in the answer cycle carries what its source held at the strobe.
  AST_STAT_READ: assert property (@(posedge mclk) disable iff (srst)
    rdStat |=> (rdData[15] && rdData[6] && rdData[2] && rdData[9:7] == 3'b000))
    else $error("fixed status bits wrong");
  AST_RD_HWEEE: assert property (@(posedge mclk) disable iff (srst)
    rdStat |=> (rdData[PEA_BIT_HWEEE] == $past(phySync_q.hwEeeEnabled)))
    else $error("hardware eee bit wrong");
  AST_RD_TXLAT: assert property (@(posedge mclk) disable iff (srst)
    rdStat |=> (rdData[PEA_BIT_TXLPILAT] == $past(txLat_q)))
    else $error("tx lpi latch bit wrong");
  AST_RD_TXLIVE: assert property (@(posedge mclk) disable iff (srst)
    rdStat |=> (rdData[PEA_BIT_TXLPI] == $past(phySync_q.txLpiActive)))
    else $error("tx lpi live bit wrong");
  AST_RD_RXLAT: assert property (@(posedge mclk) disable iff (srst)
    rdStat |=> (rdData[PEA_BIT_RXLPILAT] == $past(rxLat_q)))
    else $error("rx lpi latch bit wrong");
  AST_RD_RXLIVE: assert property (@(posedge mclk) disable iff (srst)
    rdStat |=> (rdData[PEA_BIT_RXLPI] == $past(phySync_q.rxLpiActive)))
    else $error("rx lpi live bit wrong");
  AST_RD_NPLOC: assert property (@(posedge mclk) disable iff (srst)
    rdStat |=> (rdData[PEA_BIT_NPLOC] == NP_STORE_DEDICATED))
    else $error("next page store bit wrong");
  AST_RD_PDF: assert property (@(posedge mclk) disable iff (srst)
    rdStat |=> (rdData[PEA_BIT_PDFAULT] == $past(pdf_q)))
    else $error("parallel fault bit wrong");
  AST_RD_LPNP: assert property (@(posedge mclk) disable iff (srst)
    rdStat |=> (rdData[PEA_BIT_LPNPABL] == $past(phySync_q.partnerNextPageAble)))
    else $error("partner next page bit wrong");
  AST_RD_PAGERX: assert property (@(posedge mclk) disable iff (srst)
    rdStat |=> (rdData[PEA_BIT_PAGERX] == $past(pageRx_q)))
    else $error("page received bit wrong");
  AST_RD_LPAN: assert property (@(posedge mclk) disable iff (srst)
    rdStat |=> (rdData[PEA_BIT_LPANABL] == $past(phySync_q.partnerAutonegAble)))
    else $error("partner autoneg bit wrong");

  // Read data stands one cycle only; reset clears all state
  AST_RD_IDLE: assert property (@(posedge mclk) disable iff (srst)
    !bus.rd |=> (rdData == 16'h0000))
    else $error("read data not zero when idle");
  AST_RD_UNMAP: assert property (@(posedge mclk) disable iff (srst)
    (bus.rd && !rdWake && !rdStat && !rdIrqS && bus.addr != PEA_ADDR_IRQ_MASK)
    |=> (rdData == 16'h0000))
    else $error("unmapped read not zero");
  AST_RD_MASK: assert property (@(posedge mclk) disable iff (srst)
    (bus.rd && bus.addr == PEA_ADDR_IRQ_MASK) |=> (rdData == {11'h000, $past(irqMask_q)}))
    else $error("mask read data wrong");
  AST_RST_CLEAR: assert property (@(posedge mclk)
    srst |=> (rdData == 16'h0000) && !txLat_q && !rxLat_q && !pdf_q && !pageRx_q
      && (irqStat_q == 5'h00) && (irqMask_q == 5'h00) && !irq)
    else $error("reset left state behind");

  // Interrupt status, mask and events
  // Status bits are sticky until a read, and every latch set raises its event.
  AST_IRQ_MASKW: assert property (@(posedge mclk) disable iff (srst)
    wrMask |=> (irqMask_q == $past(bus.wdata[4:0])))
    else $error("mask write lost");
  AST_MASK_HOLD: assert property (@(posedge mclk) disable iff (srst)
    !wrMask |=> $stable(irqMask_q))
    else $error("mask changed without write");
  AST_IRQ_CLR: assert property (@(posedge mclk) disable iff (srst)
    (rdIrqS && irqEv == 5'h00) |=> (irqStat_q == 5'h00))
    else $error("interrupt status not cleared on read");
  AST_IRQ_STICKY: assert property (@(posedge mclk) disable iff (srst)
    !rdIrqS |=> ((irqStat_q & $past(irqStat_q)) == $past(irqStat_q)))
    else $error("interrupt status bit dropped");
  AST_IRQ_RDDATA: assert property (@(posedge mclk) disable iff (srst)
    rdIrqS |=> (rdData == {11'h000, $past(irqStat_q)}))
    else $error("interrupt status read data wrong");
  AST_IRQ_WAKE: assert property (@(posedge mclk) disable iff (srst)
    wakeRise |=> irqStat_q[PEA_IRQ_WAKEERR])
    else $error("wake error event lost");
  AST_IRQ_TX: assert property (@(posedge mclk) disable iff (srst)
    (phySync_q.txLpiActive && !txLat_q) |=> irqStat_q[PEA_IRQ_TXLPI])
    else $error("tx lpi event lost");
  AST_IRQ_RX: assert property (@(posedge mclk) disable iff (srst)
    (phySync_q.rxLpiActive && !rxLat_q) |=> irqStat_q[PEA_IRQ_RXLPI])
    else $error("rx lpi event lost");
  AST_IRQ_PDF: assert property (@(posedge mclk) disable iff (srst)
    (phySync_q.parallelDetectFault && !pdf_q) |=> irqStat_q[PEA_IRQ_PDFAULT])
    else $error("parallel fault event lost");
  AST_IRQ_PAGE: assert property (@(posedge mclk) disable iff (srst)
    (phySync_q.pageReceived && !pageRx_q) |=> irqStat_q[PEA_IRQ_PAGERX])
    else $error("page received event lost");

endmodule // pea_status_regs

// *** dv/pea_phy_model.sv ***
`timescale 1ns/1ns
module pea_phy_model
  import pea_pkg::*;
(
  input  wire logic     mclk,
  output pea_phy_t      phy
);
  // All PHY and auto-negotiation indications start low
  initial begin
    phy = '0;
  end
  // One-cycle event, as the PHY gives for a fault, a page or a wake expiry
  task automatic pulse(input int idx);
    @(posedge mclk) phy[idx] <= 1'b1;
    @(posedge mclk) phy[idx] <= 1'b0;
  endtask
  // Held level, for live LPI and ability flags
  task automatic level(input int idx, input logic v);
    @(posedge mclk) phy[idx] <= v;
  endtask
endmodule // pea_phy_model

// *** dv/tb.sv ***
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin badCount++; \
  $display("[ERR] %0t got %h expected %h", $time, a, e); end end
module tb;
  import pea_pkg::*;
  localparam int          WAKE = 7, TXL = 6, RXL = 5, HWE = 4;
  localparam int          LPNP = 3, LPAN = 2, PDF = 1, PGR = 0;
  localparam logic [15:0] BASE = 16'h8064;
  logic        mclk;
  logic        srst;
  logic        irq;
  logic [15:0] rdData;
  logic [15:0] got;
  pea_bus_t    bus;
  pea_phy_t    phyIn;
  int          badCount;
  int          comparisons;
  pea_status_regs uut (.mclk(mclk), .srst(srst), .bus(bus), .rdData(rdData),
                       .phyIn(phyIn), .irq(irq));
  pea_phy_model far (.mclk(mclk), .phy(phyIn));
  // Clock, 10 ns period
  always #5 mclk = ~mclk;
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk) begin
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
    end
    @(posedge mclk) bus.wr <= 1'b0;
  endtask
  // One-cycle read strobe, data taken in the following cycle
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk) begin
      bus.addr <= a;
      bus.rd   <= 1'b1;
    end
    @(posedge mclk) bus.rd <= 1'b0;
    #1 got = rdData;
    `CHK(got, e)
  endtask
  // Covers the input synchroniser and edge detect
  task automatic settle();
    repeat (6) @(posedge mclk);
  endtask
  // Verdict and end of run
  task automatic conclude();
    if (badCount == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    bus = '0;
    badCount = 0;
    comparisons = 0;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    rchk(PEA_ADDR_STATUS, BASE);
    rchk(PEA_ADDR_WAKE_ERR, PEA_RST_WAKE_ERR);
    repeat (3) begin
      far.pulse(WAKE);
      settle();
    end
    rchk(PEA_ADDR_WAKE_ERR, 16'h0003);
    rchk(PEA_ADDR_WAKE_ERR, 16'h0000);
    far.level(HWE, 1'b1);
    far.level(LPNP, 1'b1);
    far.level(LPAN, 1'b1);
    settle();
    rchk(PEA_ADDR_STATUS, BASE | 16'h4009);
    far.level(HWE, 1'b0);
    far.level(LPNP, 1'b0);
    far.level(LPAN, 1'b0);
    far.level(TXL, 1'b1);
    far.level(RXL, 1'b1);
    settle();
    rchk(PEA_ADDR_STATUS, BASE | 16'h3c00);
    far.level(TXL, 1'b0);
    far.level(RXL, 1'b0);
    settle();
    rchk(PEA_ADDR_STATUS, BASE | 16'h2800);
    wr(PEA_ADDR_STATUS, 16'h2000);
    rchk(PEA_ADDR_STATUS, BASE | 16'h0800);
    wr(PEA_ADDR_STATUS, 16'h0b80);
    rchk(PEA_ADDR_STATUS, BASE);
    far.pulse(PDF);
    far.pulse(PGR);
    settle();
    rchk(PEA_ADDR_STATUS, BASE | 16'h0012);
    rchk(PEA_ADDR_STATUS, BASE);
    // Sticky event bits, mask and level interrupt
    `CHK(irq, 1'b0)
    wr(PEA_ADDR_IRQ_MASK, 16'h001f);
    #1 `CHK(irq, 1'b1)
    rchk(PEA_ADDR_IRQ_MASK, 16'h001f);
    rchk(PEA_ADDR_IRQ_STAT, 16'h001f);
    `CHK(irq, 1'b0)
    wr(PEA_ADDR_IRQ_MASK, 16'h0000);
    far.pulse(PDF);
    settle();
    `CHK(irq, 1'b0)
    wr(PEA_ADDR_IRQ_MASK, 16'h0008);
    #1 `CHK(irq, 1'b1)
    rchk(8'h0a0, 16'h0000);
    // Reset in mid-run clears the counter
    far.pulse(WAKE);
    settle();
    @(posedge mclk) srst <= 1'b1;
    @(posedge mclk) srst <= 1'b0;
    rchk(PEA_ADDR_WAKE_ERR, PEA_RST_WAKE_ERR);
    conclude();
  end
  // Watchdog against a hang
  initial begin
    #200000;
    badCount++;
    conclude();
  end
endmodule // tb
